/* File: rtl/sahp_pkg.sv */
// package: constants for the converter host port
package sahp_pkg;
	localparam int RESULT_WIDTH = 12;
	localparam int BUS_WIDTH = 8;
	localparam int BIT_CNT_WIDTH = 4;
	localparam logic [3:0] DECISIONS = 4'hC;
	localparam logic [11:0] RESULT_RESET = 12'h000;
	localparam logic [11:0] TRIAL_MSB = 12'h800;
	localparam int HI_FIELD_MSB = 11;
	localparam int HI_FIELD_LSB = 8;
	localparam int LO_FIELD_MSB = 7;
	localparam int STATUS_BIT = 7;
	localparam int AUTOZERO_NS = 10000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int AUTOZERO_CYCLES = (AUTOZERO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AZ_CNT_WIDTH = 12;
	localparam logic [11:0] AZ_DONE = 12'(AUTOZERO_CYCLES - 1);
	typedef enum logic [1:0]
	{
		SAHP_IDLE = 2'b00,
		SAHP_AZERO = 2'b01,
		SAHP_CONV = 2'b11
	} sahp_state_t;
endpackage

/* File: rtl/sahp_sync.sv */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sahp_sync #(
	parameter int WIDTH = 1
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// first flop feeds only the second
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			meta_reg <= '1;
			sync_out <= '1;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

/* File: rtl/sahp_top.sv */
// top: host port and successive approximation sequencer of the converter
`timescale 1ns/1ps
module sahp_top
	import sahp_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic byte_select,
	input wire logic conv_clk,
	input wire logic ext_clk_mode,
	input wire logic comp_in,
	output logic [sahp_pkg::BUS_WIDTH-1:0] data_out,
	output logic [sahp_pkg::BUS_WIDTH-1:0] data_oe,
	output logic busy_n,
	output logic [sahp_pkg::RESULT_WIDTH-1:0] dac_code
);
	import sahp_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [5:0] pins_sync;
	logic cs_s, rd_s, wr_s, bs_s, cclk_s, comp_s;

	sahp_sync #(.WIDTH(6)) u_sync
	(
		.mclk(mclk),
		.srst(srst),
		.async_in({cs_n, rd_n, wr_n, byte_select, conv_clk, comp_in}),
		.sync_out(pins_sync)
	);
	assign {cs_s, rd_s, wr_s, bs_s, cclk_s, comp_s} = pins_sync;

	// ------------------------------------------------------------
	// strobe decoding
	// ------------------------------------------------------------
	logic wr_act_reg, cclk_reg, ext_mode_reg;
	sahp_state_t state_reg, state_next;
	logic [11:0] sar_reg, sar_next, trial_reg, trial_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [11:0] az_cnt_reg, az_cnt_next;

	// strobes only count while select is low
	wire wr_act = ~cs_s & ~wr_s;
	wire rd_act = ~cs_s & ~rd_s;
	wire cclk_fall = cclk_reg & ~cclk_s; // decisions on falling conversion clock
	wire converting = (state_reg != SAHP_IDLE);
	wire az_done = ext_mode_reg ? cclk_fall : (az_cnt_reg == AZ_DONE);

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// next-state logic: write restarts, autozero, twelve decisions
	always_comb
	begin
		state_next = state_reg;
		sar_next = sar_reg;
		trial_next = trial_reg;
		bit_cnt_next = bit_cnt_reg;
		az_cnt_next = az_cnt_reg;
		if (wr_act)
		begin
			// write held low: abort anything and wait in autozero
			state_next = SAHP_AZERO;
			sar_next = RESULT_RESET;
			trial_next = TRIAL_MSB;
			bit_cnt_next = 4'h0;
			az_cnt_next = 12'h000;
		end
		else
		begin
			case (state_reg)
				SAHP_AZERO:
				begin
					// external clock: host stretched write over autozero
					if (az_done)
						state_next = SAHP_CONV;
					else
						az_cnt_next = az_cnt_reg + 12'h001;
				end
				SAHP_CONV:
				begin
					if (cclk_fall)
					begin
						// keep the trial bit when the comparator says input is above
						sar_next = comp_s ? (sar_reg | trial_reg) : sar_reg;
						trial_next = trial_reg >> 1;
						bit_cnt_next = bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == DECISIONS - 4'h1)
							state_next = SAHP_IDLE;
					end
				end
				default:
					state_next = SAHP_IDLE;
			endcase
		end
	end

	// state registers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_reg <= SAHP_IDLE;
			sar_reg <= RESULT_RESET;
			trial_reg <= 12'h000;
			bit_cnt_reg <= 4'h0;
			az_cnt_reg <= 12'h000;
			wr_act_reg <= 1'b0;
			cclk_reg <= 1'b1;
			ext_mode_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			sar_reg <= sar_next;
			trial_reg <= trial_next;
			bit_cnt_reg <= bit_cnt_next;
			az_cnt_reg <= az_cnt_next;
			wr_act_reg <= wr_act;
			cclk_reg <= cclk_s;
			ext_mode_reg <= ext_clk_mode; // static strap, same domain
		end
	end

	// ------------------------------------------------------------
	// data bus and status outputs
	// ------------------------------------------------------------
	// status follows the next state so it lines up with the registered busy output
	wire busy_next = (state_next != SAHP_IDLE);
	// high byte: status, three zeros, top four result bits
	wire [7:0] hi_byte = {busy_next, 3'b000, sar_next[HI_FIELD_MSB:HI_FIELD_LSB]};
	wire [7:0] lo_byte = sar_next[LO_FIELD_MSB:0];
	wire [7:0] bus_byte = bs_s ? hi_byte : lo_byte;

	// registered pin drivers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			data_out <= 8'h00;
			data_oe <= 8'h00;
			busy_n <= 1'b1;
			dac_code <= RESULT_RESET;
		end
		else
		begin
			data_out <= bus_byte;
			data_oe <= {BUS_WIDTH{rd_act}};
			busy_n <= ~busy_next;
			dac_code <= sar_next | trial_next;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_start;
		wr_act;
	endsequence
	sequence s_busy_two;
		!busy_n ##1 !busy_n;
	endsequence

	AST_OE_FOLLOWS_READ: assert property (@(posedge mclk) disable iff (srst)
		data_oe == {BUS_WIDTH{$past(rd_act)}})
		else $error("bus enable does not follow select and read");
	AST_NO_DRIVE_IDLE: assert property (@(posedge mclk) disable iff (srst)
		$past(cs_s) |-> data_oe == 8'h00)
		else $error("bus driven without select");
	AST_HI_ZEROS: assert property (@(posedge mclk) disable iff (srst)
		$past(bs_s) |-> data_out[6:4] == 3'b000)
		else $error("high byte middle bits not zero");
	AST_HI_STATUS: assert property (@(posedge mclk) disable iff (srst)
		$past(bs_s) |-> data_out[STATUS_BIT] == ~busy_n)
		else $error("status bit disagrees with busy");
	AST_LO_BYTE: assert property (@(posedge mclk) disable iff (srst)
		!$past(bs_s) |-> data_out == $past(sar_next[7:0]))
		else $error("low byte does not carry result bits");
	AST_START_BUSY: assert property (@(posedge mclk) disable iff (srst)
		s_start |=> s_busy_two)
		else $error("write did not raise busy");
	AST_RESTART: assert property (@(posedge mclk) disable iff (srst)
		(converting && wr_act) |=> state_reg == SAHP_AZERO && sar_reg == 12'h000)
		else $error("write did not restart conversion");
	AST_BUSY_MATCH: assert property (@(posedge mclk) disable iff (srst)
		busy_n == !converting)
		else $error("busy output disagrees with state");
	AST_AZ_MIN: assert property (@(posedge mclk) disable iff (srst)
		(!ext_mode_reg && state_reg == SAHP_AZERO && state_next == SAHP_CONV && !wr_act)
		|-> az_cnt_reg == AZ_DONE)
		else $error("autozero ended early");
	AST_TWELVE: assert property (@(posedge mclk) disable iff (srst)
		(state_reg == SAHP_CONV && state_next == SAHP_IDLE) |-> bit_cnt_reg == 4'hB)
		else $error("conversion did not take twelve decisions");
	AST_HI_FIELD: assert property (@(posedge mclk) disable iff (srst)
		$past(bs_s) |-> data_out[3:0] == $past(sar_next[HI_FIELD_MSB:HI_FIELD_LSB]))
		else $error("high byte low nibble does not carry top result bits");
	AST_FIRST_TRIAL: assert property (@(posedge mclk) disable iff (srst)
		s_start |=> dac_code == TRIAL_MSB)
		else $error("start did not present the msb trial");
	AST_STEP_ON_CLOCK: assert property (@(posedge mclk) disable iff (srst)
		(state_reg == SAHP_CONV && !cclk_fall && !wr_act) |=> $stable(sar_reg))
		else $error("approximation changed without a conversion clock fall");

endmodule

/* File: verification/sahp_analog_model.sv */
// partner model: conversion clock source and ideal comparator
`timescale 1ns/1ps
module sahp_analog_model
	import sahp_pkg::*;
(
	input wire logic [sahp_pkg::RESULT_WIDTH-1:0] vin,
	input wire logic [sahp_pkg::RESULT_WIDTH-1:0] dac_code,
	output logic conv_clk,
	output logic comp_in
);
	// free-running logic clock on the single clock pin, 100 ns period
	initial conv_clk = 1'b0;
	always #50 conv_clk = ~conv_clk;
	// keep the trial bit while the trial code does not exceed the input
	assign comp_in = (dac_code <= vin);
endmodule

/* File: verification/sahp_top_tb.sv */
// testbench: strobed reads, writes and full conversions through the host port
`timescale 1ns/1ps
module sahp_top_tb;
	import sahp_pkg::*;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic byte_select = 1'b0;
	logic ext_clk_mode = 1'b0;
	logic take = 1'b0;
	logic conv_clk;
	logic comp_in;
	logic busy_n;
	logic [7:0] data_out;
	logic [7:0] data_oe;
	logic [11:0] dac_code;
	logic [11:0] vin = 12'h000;
	logic [15:0] exp_q[$];
	int failures = 0;
	int checks_done = 0;
	int seed = 77;

	// 200 MHz system clock
	always #2.5 mclk = ~mclk;

	sahp_top dut_u (.mclk(mclk), .srst(srst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.byte_select(byte_select), .conv_clk(conv_clk), .ext_clk_mode(ext_clk_mode),
		.comp_in(comp_in), .data_out(data_out), .data_oe(data_oe), .busy_n(busy_n),
		.dac_code(dac_code));
	sahp_analog_model model_u (.vin(vin), .dac_code(dac_code), .conv_clk(conv_clk),
		.comp_in(comp_in));

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// busy output against the expected level
	task automatic chk_busy(input logic exp);
		chk({15'h0000, busy_n}, {15'h0000, exp});
	endtask

	// trial code against the expected value
	task automatic chk_dac(input logic [11:0] exp);
		chk({4'h0, dac_code}, {4'h0, exp});
	endtask

	// monitor: each strobed read is matched with the oldest note
	always @(posedge mclk)
		if (take)
			chk({data_oe, data_out}, exp_q.pop_front());

	// read strobe held long enough for sync and output flops
	task automatic rd(input logic cs, input logic bs, input logic [15:0] exp);
		@(negedge mclk);
		cs_n = cs;
		rd_n = 1'b0;
		byte_select = bs;
		repeat (5) @(negedge mclk);
		exp_q.push_back(exp);
		take = 1'b1;
		@(negedge mclk);
		take = 1'b0;
		cs_n = 1'b1;
		rd_n = 1'b1;
	endtask

	task automatic wr(input logic cs, input int hold);
		@(negedge mclk);
		cs_n = cs;
		wr_n = 1'b0;
		repeat (hold) @(negedge mclk);
		wr_n = 1'b1;
		cs_n = 1'b1;
	endtask

	task automatic wait_done();
		int n;
		n = 0;
		while (busy_n !== 1'b1 && n < 5000)
		begin
			@(negedge mclk);
			n++;
		end
		if (n == 5000)
		begin
			failures++;
			report_and_stop();
		end
	endtask

	// full conversion of one input value, then both bytes read back
	task automatic conv(input int hold, input logic [11:0] v);
		vin = v;
		wr(1'b0, hold);
		chk_busy(1'b0);
		chk_dac(TRIAL_MSB);
		wait_done();
		chk_dac(v);
		rd(1'b0, 1'b0, {8'hFF, vin[7:0]});
		rd(1'b0, 1'b1, {8'hFF, 4'h0, vin[11:8]});
	endtask

	initial
	begin
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		repeat (3) @(negedge mclk);
		chk_busy(1'b1);
		chk_dac(RESULT_RESET);
		rd(1'b1, 1'b0, 16'h0000);
		wr(1'b1, 4);
		repeat (4) @(negedge mclk);
		chk_busy(1'b1);
		conv(3, 12'hFFF);
		conv(3, 12'h000);
		repeat (3) conv(3, 12'($random(seed)));
		// reads in autozero show cleared approximation bits and status
		wr(1'b0, 3);
		rd(1'b0, 1'b1, 16'hFF80);
		rd(1'b0, 1'b0, 16'hFF00);
		repeat (2050) @(negedge mclk);
		conv(3, 12'($random(seed)));
		// reset in mid-conversion returns the port to idle
		wr(1'b0, 3);
		repeat (2100) @(negedge mclk);
		srst = 1'b1;
		repeat (4) @(negedge mclk);
		srst = 1'b0;
		repeat (3) @(negedge mclk);
		chk_busy(1'b1);
		chk_dac(RESULT_RESET);
		// external clock: write stretched over the autozero interval
		ext_clk_mode = 1'b1;
		conv(2100, 12'($random(seed)));
		ext_clk_mode = 1'b0;
		report_and_stop();
	end
endmodule
